// >>> bench/blpf_als_model.sv
`timescale 1ns/1ps

module blpf_als_model #(
  parameter int unsigned SETTLE = 3
) (
  input  wire logic        mclk,
  input  wire logic        on,
  input  wire logic [15:0] level,
  output logic      [15:0] als_data
);
  int unsigned settle_cnt = 0;

  initial als_data = 16'h0000;

  // Unpowered sensor gives no steady reading; a lit one settles before reporting
  always @(posedge mclk) begin
    if (!on) begin
      als_data <= ~als_data;
    end else if (level !== als_data && settle_cnt < SETTLE) begin
      settle_cnt <= settle_cnt + 1;
    end else begin
      als_data   <= level;
      settle_cnt <= 0;
    end
  end
endmodule // blpf_als_model

// >>> bench/blpf_top_properties.sv
`timescale 1ns/1ps

module blpf_props #(
  parameter int unsigned ALS_SAMPLE_CYCLES = 20
) (
  input wire logic                    mclk,
  input wire logic                    rstn,
  input wire blpf_pkg::blpf_apb_req_t apb_req,
  input wire blpf_pkg::blpf_apb_rsp_t apb_rsp,
  input wire logic [15:0]             als_data,
  input wire logic [7:0]              content_level,
  input wire logic                    backlight_pwm_output,
  input wire logic [1:0]              gamma_select
);
  import blpf_pkg::*;

  logic        wr;
  logic        rise;
  logic        chg;
  logic        pwm_d;
  logic [5:0]  ctrl;
  logic [7:0]  div;
  logic [19:0] per;
  logic [19:0] exp_per;

  assign wr      = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite & ~apb_rsp.pslverr;
  assign rise    = backlight_pwm_output & ~pwm_d;
  assign exp_per = 20'(div) << (ctrl[0] ? 10 : 11);

  // Shadow of control and divider, period counter between rising edges
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl  <= 6'h00;
      div   <= 8'h01;
      chg   <= 1'b1;
      pwm_d <= 1'b0;
      per   <= 20'h00000;
    end else begin
      if (wr && apb_req.paddr == 8'h00) ctrl <= apb_req.pwdata[5:0];
      if (wr && apb_req.paddr == 8'h08) div <= (apb_req.pwdata[7:0] == 8'h00) ? 8'h01 : apb_req.pwdata[7:0];
      chg   <= wr | (chg & ~rise);
      pwm_d <= backlight_pwm_output;
      per   <= rise ? 20'h00001 : per + 20'h00001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  ready_after_setup_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready in access cycle");
  ready_single_a: assert property ($rose(apb_rsp.pready) |=> $fell(apb_rsp.pready))
    else $error("ready held too long");
  err_decode_a: assert property (apb_rsp.pready |->
    apb_rsp.pslverr == (apb_req.paddr > 8'h1c || apb_req.paddr[1:0] != 2'b00))
    else $error("error response wrong for address");
  err_read_zero_a: assert property (apb_rsp.pready && apb_rsp.pslverr && !apb_req.pwrite |->
    apb_rsp.prdata == 32'h0)
    else $error("refused read returned data");
  sleep_dark_a: assert property ((!ctrl[1]) [*6] |-> !backlight_pwm_output)
    else $error("backlight on while asleep");
  pwm_period_a: assert property (rise && !chg |-> per == exp_per)
    else $error("pwm period wrong");
  gamma_off_a: assert property ((ctrl[1] && ctrl[5:4] == 2'b00) [*8] |-> gamma_select == 2'b00)
    else $error("gamma not original in off mode");
  gamma_still_a: assert property ((ctrl[1] && ctrl[5:4] == 2'b10) [*8] |->
    gamma_select inside {2'b01, 2'b10})
    else $error("gamma wrong in still mode");
  gamma_moving_a: assert property ((ctrl[1] && ctrl[5:4] == 2'b11) [*8] |-> gamma_select == 2'b11)
    else $error("gamma wrong in moving mode");

  cover property (rise && !chg);
  cover property (apb_rsp.pslverr);
  cover property ((!ctrl[1]) [*8]);
endmodule // blpf_props

bind blpf_top blpf_props #(
  .ALS_SAMPLE_CYCLES(ALS_SAMPLE_CYCLES)
) blpf_props_i (
  .mclk(mclk),
  .rstn(rstn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .als_data(als_data),
  .content_level(content_level),
  .backlight_pwm_output(backlight_pwm_output),
  .gamma_select(gamma_select)
);

// >>> bench/blpf_top_test.sv
`timescale 1ns/1ps

module blpf_top_test;
  import blpf_pkg::*;

  logic          mclk = 1'b0;
  logic          rstn = 1'b0;
  blpf_apb_req_t req = '0;
  blpf_apb_rsp_t rsp;
  logic          pwm;
  logic [1:0]    gam;
  logic [7:0]    content = 8'h00;
  logic [15:0]   als;
  logic [15:0]   lvl = 16'd1000;
  logic          als_on = 1'b0;
  logic [31:0]   rd;
  logic          er;
  int            error_cnt = 0;
  int            checks = 0;
  int            cyc = 0;
  int            n;
  int            hi;
  int            per;
  logic [7:0]    rst_a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
  logic [31:0]   rst_v [7] = '{32'h0, 32'h0, 32'h1, 32'hff, 32'hffffffff, 32'h80, 32'h0};
  // Control, brightness, content, ratio, level, gamma
  logic [7:0]    rows [8][6] = '{'{8'h03, 8'h80, 8'h10, 8'hff, 8'h80, 8'h00},
                                 '{8'h07, 8'h80, 8'h10, 8'h40, 8'h20, 8'h00},
                                 '{8'h13, 8'h43, 8'h10, 8'h3f, 8'h10, 8'h01},
                                 '{8'h13, 8'hc8, 8'h10, 8'hff, 8'hc8, 8'h01},
                                 '{8'h23, 8'h80, 8'h20, 8'hb3, 8'h5a, 8'h02},
                                 '{8'h23, 8'h80, 8'he0, 8'he0, 8'h70, 8'h01},
                                 '{8'h33, 8'h80, 8'h20, 8'h99, 8'h4d, 8'h03},
                                 '{8'h33, 8'h80, 8'hc0, 8'hc0, 8'h60, 8'h03}};

  blpf_top #(
    .ALS_SAMPLE_CYCLES(20)
  ) blpf_top_i (
    .mclk(mclk),
    .rstn(rstn),
    .apb_req(req),
    .apb_rsp(rsp),
    .als_data(als),
    .content_level(content),
    .backlight_pwm_output(pwm),
    .gamma_select(gam)
  );

  blpf_als_model #(
    .SETTLE(3)
  ) blpf_als_model_i (
    .mclk(mclk),
    .on(als_on),
    .level(lvl),
    .als_data(als)
  );

  always #12.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      final_report;
    end
  end

  task automatic final_report;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    // Response is sampled at the rising edge, as it stood before that edge
    do begin
      @(posedge mclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic pwm_meas(input logic [31:0] ctrl, pcfg, br, exp_hi, exp_per);
    apb(1'b1, 8'h08, pcfg);
    apb(1'b1, 8'h04, br);
    apb(1'b1, 8'h00, ctrl);
    repeat (2) @(posedge pwm);
    hi = 0;
    @(negedge mclk);
    while (pwm === 1'b1) begin
      hi++;
      @(negedge mclk);
    end
    per = hi;
    while (pwm === 1'b0) begin
      per++;
      @(negedge mclk);
    end
    chk(32'(hi), exp_hi);
    chk(32'(per), exp_per);
  endtask

  task automatic pwm_level(input logic b);
    repeat (1100) @(posedge mclk);
    hi = 0;
    repeat (1100) begin
      @(negedge mclk);
      if (pwm !== b) hi++;
    end
    chk(32'(hi), 32'h0);
  endtask

  task automatic wait_lum(input logic [15:0] v);
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h1c, 32'h0);
      k++;
    end while (rd[15:0] !== v && k < 100);
    repeat (5) @(posedge mclk);
    apb(1'b0, 8'h1c, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rst_a[i]) begin
      apb(1'b0, rst_a[i], 32'h0);
      chk(rd, rst_v[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, 8'h0c, 32'h40);
    apb(1'b1, 8'h10, 32'hff7f3f1f);
    foreach (rows[i]) begin
      content <= rows[i][2];
      apb(1'b1, 8'h04, 32'(rows[i][1]));
      apb(1'b1, 8'h00, 32'(rows[i][0]));
      repeat (8) @(posedge mclk);
      apb(1'b0, 8'h18, 32'h0);
      chk(32'(rd[16:0]), {15'h0, 1'b0, rows[i][4], rows[i][3]});
      chk(32'(gam), 32'(rows[i][5]));
    end
    // Sleep keeps the output dark, full brightness keeps it high
    apb(1'b1, 8'h04, 32'hff);
    apb(1'b1, 8'h00, 32'h01);
    pwm_level(1'b0);
    apb(1'b1, 8'h00, 32'h03);
    pwm_level(1'b1);
    pwm_meas(32'h03, 32'h0001, 32'h03, 32'd16, 32'd1024);
    pwm_meas(32'h03, 32'h1f01, 32'h00, 32'd128, 32'd1024);
    pwm_meas(32'h02, 32'h0002, 32'h03, 32'd64, 32'd4096);
    // Ambient path: steady light, then a step
    als_on <= 1'b1;
    apb(1'b1, 8'h00, 32'h0b);
    n = 0;
    do begin
      apb(1'b0, 8'h18, 32'h0);
      n++;
    end while (rd[16] !== 1'b1 && n < 200);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, {16'd1000, 16'd1000});
    lvl <= 16'd2000;
    wait_lum(16'd1600);
    chk(rd, {16'd1000, 16'd1600});
    wait_lum(16'd1700);
    chk(rd, {16'd1100, 16'd1700});
    wait_lum(16'd2000);
    apb(1'b1, 8'h14, 32'h00010040);
    wait_lum(16'd1256);
    chk(32'(rd[15:0]), 32'd1256);
    apb(1'b1, 8'h14, 32'h00ffffff);
    wait_lum(16'hffff);
    chk(32'(rd[15:0]), 32'hffff);
    final_report;
  end
endmodule // blpf_top_test

// >>> verilog/blpf_median.sv
`timescale 1ns/1ps
`include "blpf_regs.svh"

module blpf_median (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        push,
  input  wire logic        load_all,
  input  wire logic [15:0] din,
  output logic      [15:0] median
);
  import blpf_pkg::*;

  typedef struct packed {
    logic [`BLPF_MED_DEPTH-1:0][15:0] q;
    logic [15:0]                      med;
  } blpf_med_state_t;

  blpf_med_state_t st;
  blpf_med_state_t next_st;

  always_comb begin
    logic [3:0] rank;
    rank = 4'h0;
    next_st = st;
    if (load_all) begin
      for (int i = 0; i < `BLPF_MED_DEPTH; i++) begin
        next_st.q[i] = din;
      end
    end else if (push) begin
      for (int i = 0; i < `BLPF_MED_DEPTH - 1; i++) begin
        next_st.q[i] = st.q[i+1];
      end
      next_st.q[`BLPF_MED_DEPTH-1] = din;
    end
    // Rank each entry as in an ascending sorted copy
    for (int i = 0; i < `BLPF_MED_DEPTH; i++) begin
      rank = 4'h0;
      for (int j = 0; j < `BLPF_MED_DEPTH; j++) begin
        if ((st.q[j] < st.q[i]) || ((st.q[j] == st.q[i]) && (j < i))) begin
          rank = rank + 4'h1;
        end
      end
      if (rank == 4'(`BLPF_MED_RANK)) begin
        next_st.med = st.q[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign median = st.med;

endmodule // blpf_median

// >>> verilog/blpf_pkg.sv
package blpf_pkg;

  typedef enum logic [1:0] {
    BLPF_MODE_OFF,
    BLPF_MODE_UI,
    BLPF_MODE_STILL,
    BLPF_MODE_MOVING
  } blpf_mode_t;

  typedef enum logic [1:0] {
    BLPF_AMB_IDLE,
    BLPF_AMB_FILL,
    BLPF_AMB_RUN
  } blpf_amb_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } blpf_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } blpf_apb_rsp_t;

endpackage

// >>> verilog/blpf_regs.svh
`ifndef BLPF_REGS_SVH
`define BLPF_REGS_SVH

// Register byte offsets
`define BLPF_ADDR_CTRL     8'h00
`define BLPF_ADDR_BRIGHT   8'h04
`define BLPF_ADDR_PWMCFG   8'h08
`define BLPF_ADDR_FORCED   8'h0c
`define BLPF_ADDR_UI       8'h10
`define BLPF_ADDR_CALIB    8'h14
`define BLPF_ADDR_STATUS   8'h18
`define BLPF_ADDR_LUM      8'h1c

// Control, PWM config and status fields
`define BLPF_CTRL_SRC_BIT    0
`define BLPF_CTRL_AWAKE_BIT  1
`define BLPF_CTRL_FORCE_BIT  2
`define BLPF_CTRL_AMB_BIT    3
`define BLPF_CTRL_MODE_LSB   4
`define BLPF_PWMCFG_OFS_LSB  8
`define BLPF_STATUS_VALID_BIT 16

// Reset values
`define BLPF_RST_CTRL      6'h00
`define BLPF_RST_BRIGHT    8'h00
`define BLPF_RST_DIV       8'h01
`define BLPF_RST_OFS       5'h00
`define BLPF_RST_FORCED    8'hff
`define BLPF_RST_UI        32'hff_ff_ff_ff
`define BLPF_RST_GAIN      8'h80
`define BLPF_RST_CAL_OFS   16'h0000

// Timing
`define BLPF_CLK_HZ        40000000
`define BLPF_FAST_SRC_HZ   10000000
`define BLPF_SLOW_SRC_HZ   5000000
`define BLPF_ALS_RATE_HZ   220
`define BLPF_FAST_DIV      (`BLPF_CLK_HZ / `BLPF_FAST_SRC_HZ)
`define BLPF_SLOW_DIV      (`BLPF_CLK_HZ / `BLPF_SLOW_SRC_HZ)

// Filters and levels
`define BLPF_AVG_DEPTH     10
`define BLPF_MED_DEPTH     13
`define BLPF_MED_RANK      6
`define BLPF_FULL_RATIO    8'hff
`define BLPF_STILL_FLOOR   8'hb3
`define BLPF_MOVE_FLOOR    8'h99
`define BLPF_FULL_DUTY     9'h100
`define BLPF_LUM_MAX       16'hffff
`define BLPF_DIV10_MUL     20'hccccd
`define BLPF_DIV10_SHIFT   23
`define BLPF_GAIN_SHIFT    7

`endif

// >>> verilog/blpf_top.sv
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "blpf_regs.svh"

module blpf_top #(
  parameter int unsigned ALS_SAMPLE_CYCLES = `BLPF_CLK_HZ / `BLPF_ALS_RATE_HZ
) (
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire blpf_pkg::blpf_apb_req_t apb_req,
  output blpf_pkg::blpf_apb_rsp_t      apb_rsp,
  input  wire logic [15:0]             als_data,
  input  wire logic [7:0]              content_level,
  output logic                         backlight_pwm_output,
  output logic [1:0]                   gamma_select
);
  import blpf_pkg::*;

  localparam logic [17:0] SAMPLE_LAST = 18'(ALS_SAMPLE_CYCLES - 1);

  typedef struct packed {
    blpf_apb_rsp_t                    rsp;
    logic                             pwm_source_select;
    logic                             awake;
    logic                             forced_duty_enable;
    logic                             amb_enable;
    blpf_mode_t                       mode;
    logic [7:0]                       brightness_value;
    logic [7:0]                       pwm_clock_divider;
    logic [4:0]                       duty_offset;
    logic [7:0]                       forced_duty;
    logic [3:0][7:0]                  ui_mode_brightness;
    logic [7:0]                       cal_gain;
    logic [15:0]                      cal_offset;
    logic [7:0]                       adaptive_ratio_readback;
    logic [7:0]                       read_brightness_command;
    logic [2:0]                       pre;
    logic [7:0]                       div_cnt;
    logic [7:0]                       slot;
    logic                             pwm;
    logic [1:0]                       gamma;
    logic [15:0]                      als_s1;
    logic [15:0]                      als_s2;
    logic [7:0]                       cont_s1;
    logic [7:0]                       cont_s2;
    logic [15:0]                      als_s3;
    logic [7:0]                       cont_s3;
    logic [15:0]                      als_hold;
    logic [7:0]                       cont_hold;
    blpf_amb_t                        amb;
    logic [17:0]                      tick_cnt;
    logic [`BLPF_AVG_DEPTH-1:0][15:0] fifo;
    logic [3:0]                       widx;
    logic [3:0]                       fill;
    logic [19:0]                      sum;
    logic                             avg_go;
    logic                             first;
    logic [15:0]                      compensated_luminance;
    logic                             lum_valid;
    logic                             med_push;
    logic                             med_load;
  } blpf_state_t;

  blpf_state_t st;
  blpf_state_t next_st;
  logic [15:0] median;

  blpf_median blpf_median_i (
    .mclk     (mclk),
    .rstn     (rstn),
    .push     (st.med_push),
    .load_all (st.med_load),
    .din      (st.compensated_luminance),
    .median   (median)
  );

  always_comb begin
    logic        src_tick;
    logic        access;
    logic [7:0]  ratio;
    logic [7:0]  base;
    logic [15:0] scaled;
    logic [9:0]  duty_sum;
    logic [8:0]  duty;
    logic [7:0]  div_last;
    logic [19:0] avg_sum;
    logic [43:0] avg_prod;
    logic [15:0] avg;
    logic [23:0] gain_prod;
    logic [17:0] cal;
    logic [15:0] old;
    src_tick  = 1'b0;
    access    = 1'b0;
    ratio     = `BLPF_FULL_RATIO;
    base      = 8'h00;
    scaled    = 16'h0000;
    duty_sum  = 10'h000;
    duty      = 9'h000;
    div_last  = 8'h00;
    avg_sum   = 20'h00000;
    avg_prod  = 44'h0;
    avg       = 16'h0000;
    gain_prod = 24'h000000;
    cal       = 18'h00000;
    old       = 16'h0000;
    next_st   = st;

    // APB slave: response prepared in setup, completes in access
    next_st.rsp.pready  = 1'b0;
    next_st.rsp.pslverr = 1'b0;
    next_st.rsp.prdata  = 32'h0000_0000;
    access = apb_req.psel && apb_req.penable && st.rsp.pready;
    if (apb_req.psel && !apb_req.penable) begin
      next_st.rsp.pready = 1'b1;
      case (apb_req.paddr)
        `BLPF_ADDR_CTRL: begin
          next_st.rsp.prdata = {26'h0, st.mode, st.amb_enable, st.forced_duty_enable,
                                st.awake, st.pwm_source_select};
        end
        `BLPF_ADDR_BRIGHT: begin
          next_st.rsp.prdata = {24'h0, st.brightness_value};
        end
        `BLPF_ADDR_PWMCFG: begin
          next_st.rsp.prdata = {19'h0, st.duty_offset, st.pwm_clock_divider};
        end
        `BLPF_ADDR_FORCED: begin
          next_st.rsp.prdata = {24'h0, st.forced_duty};
        end
        `BLPF_ADDR_UI: begin
          next_st.rsp.prdata = st.ui_mode_brightness;
        end
        `BLPF_ADDR_CALIB: begin
          next_st.rsp.prdata = {8'h0, st.cal_offset, st.cal_gain};
        end
        `BLPF_ADDR_STATUS: begin
          next_st.rsp.prdata = {15'h0, st.lum_valid, st.read_brightness_command,
                                st.adaptive_ratio_readback};
        end
        `BLPF_ADDR_LUM: begin
          next_st.rsp.prdata = {median, st.compensated_luminance};
        end
        default: next_st.rsp.pslverr = 1'b1;
      endcase
    end
    if (access && apb_req.pwrite) begin
      case (apb_req.paddr)
        `BLPF_ADDR_CTRL: begin
          next_st.pwm_source_select  = apb_req.pwdata[`BLPF_CTRL_SRC_BIT];
          next_st.awake              = apb_req.pwdata[`BLPF_CTRL_AWAKE_BIT];
          next_st.forced_duty_enable = apb_req.pwdata[`BLPF_CTRL_FORCE_BIT];
          next_st.amb_enable         = apb_req.pwdata[`BLPF_CTRL_AMB_BIT];
          next_st.mode = blpf_mode_t'(apb_req.pwdata[`BLPF_CTRL_MODE_LSB +: 2]);
        end
        `BLPF_ADDR_BRIGHT: begin
          next_st.brightness_value = apb_req.pwdata[7:0];
        end
        `BLPF_ADDR_PWMCFG: begin
          next_st.pwm_clock_divider = apb_req.pwdata[7:0];
          next_st.duty_offset       = apb_req.pwdata[`BLPF_PWMCFG_OFS_LSB +: 5];
        end
        `BLPF_ADDR_FORCED: begin
          next_st.forced_duty = apb_req.pwdata[7:0];
        end
        `BLPF_ADDR_UI: begin
          next_st.ui_mode_brightness = apb_req.pwdata;
        end
        `BLPF_ADDR_CALIB: begin
          next_st.cal_gain   = apb_req.pwdata[7:0];
          next_st.cal_offset = apb_req.pwdata[23:8];
        end
        default: ;
      endcase
    end

    // Adaptive ratio and gamma per mode
    if (st.forced_duty_enable) begin
      ratio = st.forced_duty;
    end else begin
      case (st.mode)
        BLPF_MODE_OFF: ratio = `BLPF_FULL_RATIO;
        BLPF_MODE_UI:  ratio = st.ui_mode_brightness[st.brightness_value[7:6]];
        BLPF_MODE_STILL: begin
          ratio = (st.cont_hold > `BLPF_STILL_FLOOR) ? st.cont_hold : `BLPF_STILL_FLOOR;
        end
        BLPF_MODE_MOVING: begin
          ratio = (st.cont_hold > `BLPF_MOVE_FLOOR) ? st.cont_hold : `BLPF_MOVE_FLOOR;
        end
        default: ratio = `BLPF_FULL_RATIO;
      endcase
    end
    case (st.mode)
      BLPF_MODE_OFF:    next_st.gamma = 2'h0;
      BLPF_MODE_UI:     next_st.gamma = 2'h1;
      BLPF_MODE_STILL:  next_st.gamma = st.cont_hold[7] ? 2'h1 : 2'h2;
      BLPF_MODE_MOVING: next_st.gamma = 2'h3;
      default:          next_st.gamma = 2'h0;
    endcase
    if (!st.awake) begin
      next_st.gamma = 2'h0;
      ratio = `BLPF_FULL_RATIO;
    end
    next_st.adaptive_ratio_readback = ratio;

    // Brightness source: ambient median when enabled, awake and valid, else host value
    base = (st.amb_enable && st.lum_valid && st.awake) ? median[15:8] : st.brightness_value;
    scaled = 16'(base * ({8'h00, ratio} + 16'h0001));
    next_st.read_brightness_command = scaled[15:8];
    duty_sum = {2'b00, scaled[15:8]} + 10'h001 + {5'h00, st.duty_offset};
    duty = (duty_sum > {1'b0, `BLPF_FULL_DUTY}) ? `BLPF_FULL_DUTY : duty_sum[8:0];
    if (!st.awake) begin
      duty = 9'h000;
    end

    // Source clock enables from the free prescaler
    next_st.pre = st.pre + 3'h1;
    if (st.pwm_source_select) begin
      src_tick = ((st.pre + 3'h1) & 3'(`BLPF_FAST_DIV - 1)) == 3'h0;
    end else begin
      src_tick = ((st.pre + 3'h1) & 3'(`BLPF_SLOW_DIV - 1)) == 3'h0;
    end
    div_last = (st.pwm_clock_divider == 8'h00) ? 8'h00 : st.pwm_clock_divider - 8'h01;
    if (src_tick) begin
      if (st.div_cnt >= div_last) begin
        next_st.div_cnt = 8'h00;
        next_st.slot    = st.slot + 8'h01;
      end else begin
        next_st.div_cnt = st.div_cnt + 8'h01;
      end
    end
    next_st.pwm = {1'b0, next_st.slot} < duty;

    // Pin synchronisers
    next_st.als_s1  = als_data;
    next_st.als_s2  = st.als_s1;
    next_st.cont_s1 = content_level;
    next_st.cont_s2 = st.cont_s1;

    // Multi-bit pins taken only once stable for two cycles
    next_st.als_s3  = st.als_s2;
    next_st.cont_s3 = st.cont_s2;
    if (st.als_s2 == st.als_s3) begin
      next_st.als_hold = st.als_s2;
    end
    if (st.cont_s2 == st.cont_s3) begin
      next_st.cont_hold = st.cont_s2;
    end

    // Ambient sampling, flicker averaging and calibration
    next_st.avg_go   = 1'b0;
    next_st.med_push = 1'b0;
    next_st.med_load = 1'b0;
    avg_sum   = st.sum;
    avg_prod  = 44'(avg_sum * `BLPF_DIV10_MUL);
    avg       = avg_prod[`BLPF_DIV10_SHIFT +: 16];
    gain_prod = 24'(avg * st.cal_gain);
    cal       = {1'b0, gain_prod[23:`BLPF_GAIN_SHIFT]} + {2'b00, st.cal_offset};
    old       = st.fifo[st.widx];
    case (st.amb)
      BLPF_AMB_IDLE: begin
        next_st.tick_cnt = 18'h00000;
        next_st.fill     = 4'h0;
        next_st.widx     = 4'h0;
        next_st.sum      = 20'h00000;
        next_st.fifo     = '0;
        next_st.first    = 1'b1;
        if (st.amb_enable && st.awake) begin
          next_st.amb = BLPF_AMB_FILL;
        end
      end
      BLPF_AMB_FILL, BLPF_AMB_RUN: begin
        if (st.tick_cnt == SAMPLE_LAST) begin
          next_st.tick_cnt = 18'h00000;
          next_st.fifo[st.widx] = st.als_hold;
          next_st.sum  = st.sum + {4'h0, st.als_hold} - {4'h0, old};
          next_st.widx = (st.widx == 4'(`BLPF_AVG_DEPTH - 1)) ? 4'h0 : st.widx + 4'h1;
          if (st.fill >= 4'(`BLPF_AVG_DEPTH - 1)) begin
            next_st.fill   = 4'(`BLPF_AVG_DEPTH);
            next_st.avg_go = 1'b1;
            next_st.amb    = BLPF_AMB_RUN;
          end else begin
            next_st.fill = st.fill + 4'h1;
          end
        end else begin
          next_st.tick_cnt = st.tick_cnt + 18'h00001;
        end
        if (!(st.amb_enable && st.awake)) begin
          next_st.amb = BLPF_AMB_IDLE;
        end
      end
      default: next_st.amb = BLPF_AMB_IDLE;
    endcase
    if (st.avg_go) begin
      next_st.compensated_luminance = cal[17:16] != 2'b00 ? `BLPF_LUM_MAX : cal[15:0];
      next_st.lum_valid = 1'b1;
      next_st.first     = 1'b0;
      next_st.med_load  = st.first;
      next_st.med_push  = !st.first;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.amb <= BLPF_AMB_IDLE;
      st.mode <= BLPF_MODE_OFF;
      st.brightness_value <= `BLPF_RST_BRIGHT;
      st.pwm_clock_divider <= `BLPF_RST_DIV;
      st.duty_offset <= `BLPF_RST_OFS;
      st.forced_duty <= `BLPF_RST_FORCED;
      st.ui_mode_brightness <= `BLPF_RST_UI;
      st.cal_gain <= `BLPF_RST_GAIN;
      st.cal_offset <= `BLPF_RST_CAL_OFS;
      st.adaptive_ratio_readback <= `BLPF_FULL_RATIO;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp              = st.rsp;
  assign backlight_pwm_output = st.pwm;
  assign gamma_select         = st.gamma;

endmodule // blpf_top
